// file: rtl/sdm_monitor.sv
module sdm_monitor #(
  parameter int ASSERT_CYC = sdm_pkg::ASSERT_DEB_CYC,
  parameter int RELEASE_CYC = sdm_pkg::RELEASE_DEB_CYC,
  parameter int FREQ_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_overload_current_limit,
  input wire sdm_pkg::sdm_fault_s i_fault,
  input wire logic i_bist_done,
  input wire logic i_bist_fail,
  input wire logic i_osc_tick,
  input wire logic i_meas_window,
  output logic [3:0] o_out_en,
  output logic o_irq,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  import sdm_pkg::*;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic [7:0] wa;
  logic [31:0] wd;
  logic wr_ok;

  assign o_awready = !aw_hold_q && !bvalid_q;
  assign o_wready = !w_hold_q && !bvalid_q;
  assign o_arready = !rvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  // write executes once address and data have both arrived
  assign wr_fire = (aw_hold_q || (i_awvalid && o_awready)) &&
                   (w_hold_q || (i_wvalid && o_wready)) && !bvalid_q;
  assign wa = aw_hold_q ? awaddr_q : i_awaddr;
  assign wd = w_hold_q ? wdata_q : i_wdata;
  assign wr_ok = wa == ADDR_IRQ_STAT || wa == ADDR_IRQ_MASK || wa == ADDR_STATIC_CLR ||
                 wa == ADDR_FREQ_LO || wa == ADDR_FREQ_HI || wa == ADDR_ECC_DATA ||
                 wa == ADDR_ECC_CODE;
  logic [3:0] ws;
  assign ws = w_hold_q ? wstrb_q : i_wstrb;
  logic wr_clr, wr_mask, wr_lo, wr_hi, wr_istat, wr_ed, wr_ec;
  assign wr_istat = wr_fire && wa == ADDR_IRQ_STAT;
  assign wr_mask = wr_fire && wa == ADDR_IRQ_MASK;
  assign wr_clr = wr_fire && wa == ADDR_STATIC_CLR;
  assign wr_lo = wr_fire && wa == ADDR_FREQ_LO;
  assign wr_hi = wr_fire && wa == ADDR_FREQ_HI;
  assign wr_ed = wr_fire && wa == ADDR_ECC_DATA;
  assign wr_ec = wr_fire && wa == ADDR_ECC_CODE;
  logic lock_clr;
  assign lock_clr = wr_clr && ws[0] && wd[B_OVL_STATIC]; // R4

  // write channel capture and response
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (i_awvalid && o_awready) begin
          aw_hold_q <= 1'b1;
          awaddr_q <= i_awaddr;
        end
        if (i_wvalid && o_wready) begin
          w_hold_q <= 1'b1;
          wdata_q <= i_wdata;
          wstrb_q <= i_wstrb;
        end
        if (bvalid_q && i_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // overload protection
  // ---------------------------------------------------------------
  sdm_ovl_e ovl_q;
  logic [31:0] deb_q;
  logic [3:0] chk_q;
  logic ovl_any;
  assign ovl_any = |i_overload_current_limit;

  // debounce, retry and lock-out sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovl_q <= OVL_RUN;
      deb_q <= 32'h00000000;
      chk_q <= 4'h0;
    end else begin
      case (ovl_q)
        OVL_RUN: begin
          deb_q <= 32'h00000000;
          if (ovl_any) begin
            ovl_q <= OVL_ASSERT;
          end else if (o_out_en == 4'hF) begin
            chk_q <= 4'h0; // R18
          end
        end
        OVL_ASSERT: begin
          if (!ovl_any) begin
            ovl_q <= OVL_RUN;
            deb_q <= 32'h00000000;
          end else if (deb_q >= 32'(ASSERT_CYC - 1)) begin
            ovl_q <= OVL_OFF; // R1
            deb_q <= 32'h00000000;
            if (chk_q >= 4'(OVL_CHECKS)) begin
              ovl_q <= OVL_LOCK; // R3
            end
          end else begin
            deb_q <= deb_q + 32'h00000001;
          end
        end
        OVL_OFF: begin
          if (deb_q >= 32'(RELEASE_CYC - 1)) begin
            ovl_q <= OVL_RUN; // R2
            deb_q <= 32'h00000000;
            if (chk_q != 4'(OVL_CHECKS)) begin
              chk_q <= chk_q + 4'h1; // R18
            end
          end else begin
            deb_q <= deb_q + 32'h00000001;
          end
        end
        OVL_LOCK: begin
          if (lock_clr) begin
            ovl_q <= OVL_RUN; // R4
            chk_q <= 4'h0; // R18
          end
        end
        default: ovl_q <= OVL_RUN;
      endcase
    end
  end

  // outputs driven only while running or in assert debounce
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_en <= 4'h0;
    end else begin
      o_out_en <= (ovl_q == OVL_RUN || ovl_q == OVL_ASSERT) ? 4'hF : 4'h0; // R1
    end
  end

  // ---------------------------------------------------------------
  // start-up self-test capture
  // ---------------------------------------------------------------
  logic bist_seen_q, bist_err_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bist_seen_q <= 1'b0;
      bist_err_q <= 1'b0;
    end else begin
      bist_err_q <= !bist_seen_q && i_bist_done && i_bist_fail; // R11
      if (i_bist_done) begin
        bist_seen_q <= 1'b1; // R16
      end
    end
  end

  // ---------------------------------------------------------------
  // ecc protected scratch word (hamming 16+5 plus parity)
  // ---------------------------------------------------------------
  logic [15:0] ecc_data_q;
  logic [5:0] ecc_code_q;
  logic [15:0] ecc_corr;
  logic ecc_sec, ecc_ded;

  function automatic logic [5:0] sdm_ecc_gen(input logic [15:0] d);
    logic [20:0] cw;
    logic [4:0] p;
    int k;
    cw = '0;
    p = '0;
    k = 0;
    for (int i = 1; i <= 21; i++) begin
      if ((i & (i - 1)) != 0) begin
        cw[i-1] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 5; b++) begin
      for (int i = 1; i <= 21; i++) begin
        if (((i >> b) & 1) == 1) begin
          p[b] = p[b] ^ cw[i-1];
        end
      end
    end
    return {^d ^ ^p, p};
  endfunction

  // decode with single correction and double detection
  always_comb begin
    logic [5:0] rc;
    logic [4:0] syn;
    logic ov;
    int k;
    rc = sdm_ecc_gen(ecc_data_q);
    syn = rc[4:0] ^ ecc_code_q[4:0];
    ov = ^ecc_data_q ^ ^ecc_code_q;
    ecc_corr = ecc_data_q;
    k = 0;
    for (int i = 1; i <= 21; i++) begin
      if ((i & (i - 1)) != 0) begin
        if (ov && syn == 5'(i)) begin
          ecc_corr[k] = ~ecc_data_q[k]; // R12
        end
        k++;
      end
    end
    ecc_sec = ov; // R12
    ecc_ded = !ov && syn != 5'h00; // R12
  end

  // data write regenerates code; code write allows fault injection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ecc_data_q <= 16'h0000;
      ecc_code_q <= 6'h00;
    end else if (wr_ed) begin
      ecc_data_q <= wd[15:0];
      ecc_code_q <= sdm_ecc_gen(wd[15:0]);
    end else if (wr_ec) begin
      ecc_code_q <= wd[5:0];
    end
  end

  // ---------------------------------------------------------------
  // oscillator frequency measurement
  // ---------------------------------------------------------------
  logic [FREQ_W-1:0] cnt_q, meas_q, lo_q, hi_q;
  logic win_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      meas_q <= '0;
      win_q <= 1'b0;
    end else begin
      win_q <= i_meas_window;
      if (win_q && !i_meas_window) begin
        meas_q <= cnt_q; // R14
        cnt_q <= '0;
      end else if (i_meas_window && i_osc_tick && cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1; // R14
      end
    end
  end

  // host programmed limits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_q <= FREQ_W'(FREQ_LO_RST);
      hi_q <= FREQ_W'(FREQ_HI_RST);
    end else begin
      if (wr_lo) lo_q <= wd[FREQ_W-1:0]; // R15
      if (wr_hi) hi_q <= wd[FREQ_W-1:0]; // R15
    end
  end

  // ---------------------------------------------------------------
  // diagnostic flags
  // ---------------------------------------------------------------
  logic [FLAG_W-1:0] cond, flags_q;
  always_comb begin
    cond = '0;
    cond[B_OVL] = ovl_any || ovl_q != OVL_RUN; // R1
    cond[B_OVL_STATIC] = ovl_q == OVL_LOCK && !lock_clr; // R3
    cond[B_RX_COIL] = i_fault.rx_short_between || i_fault.rx_short_gnd ||
                      i_fault.rx_short_vdd || i_fault.rx_open; // R5
    cond[B_TX_COIL] = i_fault.tx_fail; // R6
    cond[B_TEMP] = i_fault.temp_warn || i_fault.temp_fail; // R7
    cond[B_SUPPLY] = i_fault.supply_fail; // R8
    cond[B_AGC] = i_fault.agc_at_min || i_fault.agc_at_max; // R9
    cond[B_DIGITAL] = i_fault.digital_err; // R10
    cond[B_BIST] = bist_err_q; // R11
    cond[B_ECC] = ecc_sec || ecc_ded; // R13
    cond[B_FREQ] = meas_q < lo_q || meas_q > hi_q; // R15
  end

  // temporary bits follow, static bits latch; set beats clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= '0;
    end else begin
      for (int i = 0; i < FLAG_W; i++) begin
        if (!STATIC_MASK[i]) begin
          flags_q[i] <= cond[i]; // R17
        end else if (cond[i]) begin
          flags_q[i] <= 1'b1; // R17
        end else if (wr_clr && wd[i]) begin
          flags_q[i] <= 1'b0; // R4
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [FLAG_W-1:0] ist_q, imask_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ist_q <= '0;
      imask_q <= '0;
    end else begin
      ist_q <= (ist_q & ~(wr_istat ? wd[FLAG_W-1:0] : '0)) | flags_q;
      if (wr_mask) imask_q <= wd[FLAG_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(ist_q & imask_q);
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      case (i_araddr)
        ADDR_FLAGS: rdata_q <= 32'(flags_q);
        ADDR_IRQ_STAT: rdata_q <= 32'(ist_q);
        ADDR_IRQ_MASK: rdata_q <= 32'(imask_q);
        ADDR_STATIC_CLR: rdata_q <= 32'h00000000;
        ADDR_FREQ_MEAS: rdata_q <= 32'(meas_q);
        ADDR_FREQ_LO: rdata_q <= 32'(lo_q);
        ADDR_FREQ_HI: rdata_q <= 32'(hi_q);
        ADDR_ECC_DATA: rdata_q <= 32'(ecc_data_q);
        ADDR_ECC_CODE: rdata_q <= 32'(ecc_code_q);
        ADDR_ECC_READ: rdata_q <= {14'h0, ecc_ded, ecc_sec, ecc_corr}; // R12
        ADDR_OVL_CNT: rdata_q <= {26'h0, ovl_q, chk_q};
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// file: shared/sdm_pkg.sv
// Overview of operation
// R1 - over-current on any buffer sets overload flag; after assert debounce, outputs tri-state
// R2 - after release debounce, outputs re-enable and over-current is checked again
// R3 - overload still present after eight checks: outputs stay off, static flag set
// R4 - static overload leaves only on reset or host clear write; outputs re-enabled
// R5 - receiver coil shorts or open coil set temporary receiver coil flag
// R6 - transmitter coil failure asserts temporary transmitter coil flag
// R7 - temperature warning or failure reported through temporary junction temperature flag
// R8 - internal supply failure sets latched static supply flag
// R9 - gain control at either programmed limit asserts temporary gain flag
// R10 - internal digital error sets latched static digital flag
// R11 - self-test runs only at start-up; failure sets latched self-test flag
// R12 - protected words carry code correcting single and detecting double bit errors
// R13 - any single or double bit code error raises an alarm flag
// R14 - oscillator frequency measured internally, stored as proportional register value
// R15 - host programs bounds; outside them raises oscillator frequency alarm
// R16 - continuous checks evaluated repeatedly; start-up checks evaluated once only
// R17 - temporary flags follow condition; static flags hold until reset or host clear
// R18 - saturating overload check counter, reset on pass or static clear
package sdm_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATIC_CLR = 8'h0C;
  localparam logic [7:0] ADDR_FREQ_MEAS = 8'h10;
  localparam logic [7:0] ADDR_FREQ_LO = 8'h14;
  localparam logic [7:0] ADDR_FREQ_HI = 8'h18;
  localparam logic [7:0] ADDR_ECC_DATA = 8'h1C;
  localparam logic [7:0] ADDR_ECC_CODE = 8'h20;
  localparam logic [7:0] ADDR_ECC_READ = 8'h24;
  localparam logic [7:0] ADDR_OVL_CNT = 8'h28;
  // ---------------------------------------------------------------
  // flag bit positions
  // ---------------------------------------------------------------
  localparam int FLAG_W = 11;
  localparam int B_OVL = 0;
  localparam int B_OVL_STATIC = 1;
  localparam int B_RX_COIL = 2;
  localparam int B_TX_COIL = 3;
  localparam int B_TEMP = 4;
  localparam int B_SUPPLY = 5;
  localparam int B_AGC = 6;
  localparam int B_DIGITAL = 7;
  localparam int B_BIST = 8;
  localparam int B_ECC = 9;
  localparam int B_FREQ = 10;
  localparam logic [FLAG_W-1:0] STATIC_MASK = 11'h3A2;
  // ---------------------------------------------------------------
  // timing and reset values
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int ASSERT_DEB_US = 10;
  localparam int RELEASE_DEB_US = 100;
  localparam int ASSERT_DEB_CYC = ASSERT_DEB_US * CLK_MHZ;
  localparam int RELEASE_DEB_CYC = RELEASE_DEB_US * CLK_MHZ;
  localparam int OVL_CHECKS = 8;
  localparam logic [15:0] FREQ_LO_RST = 16'h0000;
  localparam logic [15:0] FREQ_HI_RST = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // fault inputs from the analog side
  typedef struct packed {
    logic rx_short_between;
    logic rx_short_gnd;
    logic rx_short_vdd;
    logic rx_open;
    logic tx_fail;
    logic temp_warn;
    logic temp_fail;
    logic supply_fail;
    logic agc_at_min;
    logic agc_at_max;
    logic digital_err;
  } sdm_fault_s;
  typedef enum logic [1:0] {OVL_RUN, OVL_ASSERT, OVL_OFF, OVL_LOCK} sdm_ovl_e;
endpackage

// file: verification/sdm_load_model.sv
module sdm_load_model (
  input wire logic [3:0] i_out_en,
  input wire logic [3:0] i_short,
  output logic [3:0] o_over
);
  timeunit 1ns;
  timeprecision 1ps;
  // a shorted load draws over-current only while its buffer drives
  assign o_over = i_out_en & i_short;
endmodule

// file: verification/sdm_monitor_assertions.sv
module sdm_chk
  import sdm_pkg::*;
#(
  parameter int ASSERT_CYC = 4,
  parameter int RELEASE_CYC = 8,
  parameter int FREQ_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_overload_current_limit,
  input wire logic [3:0] o_out_en,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready
);
  timeunit 1ns;
  timeprecision 1ps;
  int oc_cnt_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // cycles of over-current seen while all outputs still drive
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oc_cnt_q <= 0;
    end else if ((|i_overload_current_limit) && o_out_en == 4'hF) begin
      oc_cnt_q <= oc_cnt_q + 1;
    end else begin
      oc_cnt_q <= 0;
    end
  end
  property p_all_four; o_out_en == 4'h0 || o_out_en == 4'hF; endproperty
  a_all_four: assert property (p_all_four) else $error("outputs not switched together");
  property p_deb; oc_cnt_q <= ASSERT_CYC + 2; endproperty
  a_deb: assert property (p_deb) else $error("outputs not off after debounce");
  property p_off_cause; $fell(o_out_en[0]) |-> $past(|i_overload_current_limit); endproperty
  a_off_cause: assert property (p_off_cause) else $error("outputs off without overload");
  property p_retry_hold; $fell(o_out_en[0]) |=> (o_out_en == 4'h0) [*4]; endproperty
  a_retry_hold: assert property (p_retry_hold) else $error("retry came too early");
  property p_rd_lat; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat; i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_refuse; o_bvalid |-> !o_awready && !o_wready; endproperty
  a_refuse: assert property (p_refuse) else $error("write taken while answer pending");
  property p_unmap;
    i_arvalid && o_arready && i_araddr > ADDR_OVL_CNT |=> o_rresp == RESP_SLVERR && o_rdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  c_off: cover property ($fell(o_out_en[0]));
  c_on: cover property ($rose(o_out_en[0]));
  c_err: cover property (o_rvalid && o_rresp == RESP_SLVERR);
endmodule

bind sdm_monitor sdm_chk #(
  .ASSERT_CYC(ASSERT_CYC),
  .RELEASE_CYC(RELEASE_CYC),
  .FREQ_W(FREQ_W)
) u_chk (.*);

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sdm_pkg::*;
  logic clk, rst_n, bd, bf, tick, win, irq, st;
  logic [3:0] ocl, shrt, out_en, wstrb;
  sdm_fault_s flt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  int fail_count, cmp_count;
  int fb[11] = '{B_RX_COIL, B_RX_COIL, B_RX_COIL, B_RX_COIL, B_TX_COIL, B_TEMP, B_TEMP,
                 B_SUPPLY, B_AGC, B_AGC, B_DIGITAL};
  sdm_monitor #(.ASSERT_CYC(4), .RELEASE_CYC(8), .FREQ_W(16)) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_overload_current_limit(ocl), .i_fault(flt),
    .i_bist_done(bd), .i_bist_fail(bf), .i_osc_tick(tick), .i_meas_window(win),
    .o_out_en(out_en), .o_irq(irq), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready)
  );
  sdm_load_model u_load (.i_out_en(out_en), .i_short(shrt), .o_over(ocl));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tmo();
    fail_count++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // write: address and data offered together, released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int n;
    n = 0;
    b = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 50) begin
      @(negedge clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b) tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    int n;
    n = 0;
    r = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r && n < 50) begin
      @(negedge clk);
      ar = arvalid & arready;
      r = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r) tmo();
  endtask
  task automatic wait_en(input logic [3:0] v);
    int n;
    n = 0;
    while (out_en !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (out_en !== v) tmo();
    chk(out_en, v);
    @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(out_en, 4'hF);
    rd(ADDR_FREQ_HI);
    chk(rv, 32'hFFFF);
    rd(8'h40);
    chk(rv, 32'h0);
    chk(rs, RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_bist();
    @(posedge clk);
    bd <= 1'b1;
    @(posedge clk);
    bd <= 1'b0;
    rd(ADDR_FLAGS);
    chk(rv, 32'h1 << B_BIST);
    wr(ADDR_STATIC_CLR, 32'h1 << B_BIST);
    rd(ADDR_FLAGS);
    chk(rv, 32'h0);
    bd <= 1'b1;
    @(posedge clk);
    bd <= 1'b0;
    rd(ADDR_FLAGS);
    chk(rv, 32'h0);
    $display("self-test test done");
  endtask
  task automatic t_faults();
    for (int i = 0; i < 11; i++) begin
      flt <= sdm_fault_s'(11'h400 >> i);
      cyc(3);
      rd(ADDR_FLAGS);
      chk(rv, 32'h1 << fb[i]);
      flt <= '0;
      cyc(3);
      rd(ADDR_FLAGS);
      st = STATIC_MASK[fb[i]];
      chk(rv, st ? 32'h1 << fb[i] : 32'h0);
      if (st) begin
        wr(ADDR_STATIC_CLR, 32'h1 << fb[i]);
        rd(ADDR_FLAGS);
        chk(rv, 32'h0);
      end
    end
    $display("fault flag test done");
  endtask
  task automatic t_irq();
    wr(ADDR_IRQ_STAT, 32'h7FF);
    flt <= sdm_fault_s'(11'h040);
    cyc(3);
    chk(irq, 1'b0);
    rd(ADDR_IRQ_STAT);
    chk(rv, 32'h1 << B_TX_COIL);
    wr(ADDR_IRQ_MASK, 32'h1 << B_TX_COIL);
    cyc(2);
    chk(irq, 1'b1);
    flt <= '0;
    cyc(3);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h1 << B_TX_COIL);
    cyc(2);
    chk(irq, 1'b0);
    $display("interrupt test done");
  endtask
  task automatic t_freq();
    win <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    win <= 1'b0;
    cyc(3);
    rd(ADDR_FREQ_MEAS);
    chk(rv, 32'd20);
    rd(ADDR_FLAGS);
    chk(rv, 32'h0);
    wr(ADDR_FREQ_LO, 32'd21);
    rd(ADDR_FLAGS);
    chk(rv, 32'h1 << B_FREQ);
    wr(ADDR_FREQ_LO, 32'd20);
    rd(ADDR_FLAGS);
    chk(rv, 32'h0);
    wr(ADDR_FREQ_HI, 32'd19);
    rd(ADDR_FLAGS);
    chk(rv, 32'h1 << B_FREQ);
    wr(ADDR_FREQ_HI, 32'hFFFF);
    $display("frequency test done");
  endtask
  task automatic t_ecc();
    logic [31:0] c;
    wr(ADDR_ECC_DATA, 32'h1234);
    rd(ADDR_ECC_CODE);
    c = rv;
    rd(ADDR_ECC_READ);
    chk(rv, 32'h1234);
    wr(ADDR_ECC_DATA, 32'h1235);
    wr(ADDR_ECC_CODE, c);
    rd(ADDR_ECC_READ);
    chk(rv, 32'h11234);
    rd(ADDR_FLAGS);
    chk(rv, 32'h1 << B_ECC);
    wr(ADDR_ECC_CODE, c ^ 32'h1);
    rd(ADDR_ECC_READ);
    chk(rv >> 16, 32'h2);
    wr(ADDR_ECC_DATA, 32'h0);
    wr(ADDR_STATIC_CLR, 32'h1 << B_ECC);
    rd(ADDR_FLAGS);
    chk(rv, 32'h0);
    $display("ecc test done");
  endtask
  task automatic t_ovl();
    int n;
    shrt <= 4'h1;
    cyc(2);
    shrt <= 4'h0;
    cyc(20);
    chk(out_en, 4'hF);
    shrt <= 4'h2;
    wait_en(4'h0);
    shrt <= 4'h0;
    wait_en(4'hF);
    rd(ADDR_OVL_CNT);
    chk(rv, 32'h0);
    shrt <= 4'h8;
    n = 0;
    rv = '0;
    while (!rv[B_OVL_STATIC] && n < 100) begin
      rd(ADDR_FLAGS);
      n++;
    end
    if (!rv[B_OVL_STATIC]) tmo();
    cyc(40);
    chk(out_en, 4'h0);
    rd(ADDR_OVL_CNT);
    chk(rv[5:4], OVL_LOCK);
    shrt <= 4'h0;
    wr(ADDR_STATIC_CLR, 32'h1 << B_OVL_STATIC);
    wait_en(4'hF);
    rd(ADDR_OVL_CNT);
    chk(rv, 32'h0);
    rd(ADDR_FLAGS);
    chk(rv, 32'h0);
    $display("overload test done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, bd, tick, win, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, rv, rs, shrt, st} = '0;
    bf = 1'b1;
    wstrb = 4'hF;
    flt = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    t_reset();
    t_bist();
    t_faults();
    t_irq();
    t_freq();
    t_ecc();
    t_ovl();
    wrap_up();
  end
endmodule
